// file: hw/aea_pkg.sv
// Package for the apparent energy accumulator: widths, field positions,
// mode codes and timing counts shared by the datapath and its divider.
// Assumes one master clock drives the whole block.
package aea_pkg;

    localparam int RMS_W         = 24;  // Width of each rms input
    localparam int TERM_W        = 24;  // Width of one unscaled phase term
    localparam int GAIN_W        = 12;  // Signed gain width
    localparam int GAIN_SHIFT    = 12;  // Gain is a fraction of 2^12
    localparam int ACC_W         = 49;  // Internal accumulator width
    localparam int ENERGY_W      = 24;  // Readable energy width
    localparam int DIV_W         = 8;   // Divider setting width
    localparam int SUM_W         = 28;  // Signed width of the phase sum

    // Mode register fields
    localparam int MODE_HI       = 7;
    localparam int MODE_LO       = 6;
    localparam int TERM_EN_HI    = 2;
    localparam int TERM_EN_LO    = 0;

    // Accumulation interval, in master clock periods, and its figure
    localparam int ACC_PERIOD_NS = 1200;
    localparam int MASTER_MHZ    = 10;
    localparam int ACC_PERIOD_CLK = ACC_PERIOD_NS * MASTER_MHZ / 1000;
    localparam logic [3:0] ACC_CNT_LAST = 4'(ACC_PERIOD_CLK - 1);
    localparam logic [3:0] ACC_CNT_RST  = 4'h0;

    localparam logic [ACC_W-1:0]    ACC_RST    = 49'h0;
    localparam logic [ENERGY_W-1:0] ENERGY_RST = 24'h0;
    localparam logic [DIV_W-1:0]    DIV_ZERO   = 8'h00;
    localparam logic [DIV_W-1:0]    DIV_ONE    = 8'h01;

    typedef enum logic [1:0] {
        AEA_SUM_ALL   = 2'b00,
        AEA_SUM_AVGAC = 2'b01,
        AEA_SUM_DELTA = 2'b10,
        AEA_SUM_SPARE = 2'b11
    } aea_mode_type;

    typedef struct packed {
        logic [RMS_W-1:0] voltA;
        logic [RMS_W-1:0] voltB;
        logic [RMS_W-1:0] voltC;
        logic [RMS_W-1:0] currA;
        logic [RMS_W-1:0] currB;
        logic [RMS_W-1:0] currC;
    } aea_rms_type;

    typedef struct packed {
        logic signed [GAIN_W-1:0] gainA;
        logic signed [GAIN_W-1:0] gainB;
        logic signed [GAIN_W-1:0] gainC;
    } aea_gain_type;

endpackage

// file: hw/aea_energy_divide.sv
// Divides a signed accumulator by an 8-bit setting and registers the top
// 24 bits of the quotient. Assumes its inputs come from the same clock.
`timescale 1ns/10ps
module aea_energy_divide (
    // Clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // Operands
    input  wire logic signed [aea_pkg::ACC_W-1:0] accValue,
    input  wire logic [aea_pkg::DIV_W-1:0]       divSetting,
    // Result
    output logic [aea_pkg::ENERGY_W-1:0]         energy
);
    import aea_pkg::*;

    logic [DIV_W-1:0]        divEff;
    logic signed [ACC_W-1:0] quotient;

    // Zero setting acts as one
    assign divEff   = (divSetting == DIV_ZERO) ? DIV_ONE : divSetting;
    assign quotient = accValue / $signed(ACC_W'({1'b0, divEff}));

    always_ff @(posedge clock) begin
        if (rst) begin
            energy <= ENERGY_RST;
        end else begin
            energy <= quotient[ACC_W-1 -: ENERGY_W];
        end
    end

endmodule // aea_energy_divide

// file: hw/aea_accumulator.sv
// Apparent energy accumulator: per-phase rms products, gain scaling,
// phase combination, 49-bit accumulation, division and energy outputs.
// Assumes rms, gain and mode inputs come from logic on the same clock.
//
// Notes on behaviour
// - The phase combination comes from bits 7 and 6 of the mode register.
// - Each of the three sum terms is added only when its enable bit is 1.
// - Mode 0 adds A, B, C products; mode 1 middle term is (VA+VC)/2 times IB; mode 2 middle term is VA times IB.
// - Each phase term is scaled by one plus its signed gain over 2^12.
// - The active power gain also scales each apparent term.
// - A hidden 49-bit accumulator collects the sum; energy shows its upper 24 bits.
// - One accumulation happens every 12 master clock periods.
// - Each accumulation is a signed two's-complement addition.
// - The accumulator is divided by the 8-bit divider, zero acting as one.
// - A second 24-bit copy has its accumulation cleared by each read.
// - On positive accumulator overflow the energy wraps to full-scale negative divided by the divider and keeps rising.
// - Reaching half full scale flags an event and drives the interrupt low when enabled.
// - Apparent gains are 12-bit signed; 7FFh scales most, 800h least.
// - In mode 2 the middle term is phase A voltage times phase B current.
`timescale 1ns/10ps
module aea_accumulator (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Configuration
    input  wire logic [7:0]                    apparentModeRegister,
    input  wire logic [aea_pkg::DIV_W-1:0]     apparentEnergyDivider,
    input  wire aea_pkg::aea_gain_type         apparentGainSettings,
    input  wire aea_pkg::aea_gain_type         activePowerGainSettings,
    input  wire logic                          halfFullEnable,
    // Upstream rms values
    input  wire aea_pkg::aea_rms_type          rmsValues,
    // Register reads
    input  wire logic                          clearOnReadStrobe,
    input  wire logic                          halfFullAck,
    // Results
    output logic [aea_pkg::ENERGY_W-1:0]       apparentEnergyTotal,
    output logic [aea_pkg::ENERGY_W-1:0]       apparentEnergyClearOnRead,
    output logic                               halfFullFlag,
    output logic                               irq_n
);
    import aea_pkg::*;

    // Upper bits of an rms product form one unscaled term
    function automatic logic [TERM_W-1:0] rmsProduct(input logic [RMS_W-1:0] v,
                                                     input logic [RMS_W-1:0] i);
        logic [2*RMS_W-1:0] prod;
        prod = (2*RMS_W)'(v) * (2*RMS_W)'(i);
        return prod[2*RMS_W-1 -: TERM_W];
    endfunction

    // Term times (1 + gain/2^12)
    function automatic logic signed [SUM_W-1:0] gainScale(input logic signed [SUM_W-1:0] t,
                                                          input logic signed [GAIN_W-1:0] g);
        logic signed [SUM_W+GAIN_W-1:0] prod;
        prod = (SUM_W+GAIN_W)'(t) * (SUM_W+GAIN_W)'(g);
        return t + SUM_W'(prod >>> GAIN_SHIFT);
    endfunction

    aea_mode_type                 sumMode;
    logic [TERM_EN_HI:TERM_EN_LO] termEnable;
    logic [RMS_W:0]               voltAcSum;
    logic [TERM_W-1:0]            rawA;
    logic [TERM_W-1:0]            rawB;
    logic [TERM_W-1:0]            rawC;
    logic signed [SUM_W-1:0]      termA;
    logic signed [SUM_W-1:0]      termB;
    logic signed [SUM_W-1:0]      termC;
    logic signed [SUM_W-1:0]      totalPower;
    logic [3:0]                   periodCnt_q;
    logic                         accTick;
    logic signed [ACC_W-1:0]      accTotal_q;
    logic signed [ACC_W-1:0]      accClear_q;
    logic [1:0]                   topBitsPrev_q;
    logic                         halfEvent;

    assign sumMode    = aea_mode_type'(apparentModeRegister[MODE_HI:MODE_LO]);
    assign termEnable = apparentModeRegister[TERM_EN_HI:TERM_EN_LO];
    assign voltAcSum  = {1'b0, rmsValues.voltA} + {1'b0, rmsValues.voltC};

    // Middle term depends on the phase combination
    always_comb begin
        rawA = rmsProduct(rmsValues.voltA, rmsValues.currA);
        rawC = rmsProduct(rmsValues.voltC, rmsValues.currC);
        case (sumMode)
            AEA_SUM_ALL:   rawB = rmsProduct(rmsValues.voltB, rmsValues.currB);
            AEA_SUM_AVGAC: rawB = rmsProduct(voltAcSum[RMS_W:1], rmsValues.currB);
            AEA_SUM_DELTA: rawB = rmsProduct(rmsValues.voltA, rmsValues.currB);
            AEA_SUM_SPARE: rawB = rmsProduct(rmsValues.voltB, rmsValues.currB);
            default:       rawB = rmsProduct(rmsValues.voltB, rmsValues.currB);
        endcase
    end

    // Apparent gain then active power gain on every phase term
    assign termA = gainScale(gainScale(SUM_W'(rawA), apparentGainSettings.gainA),
                             activePowerGainSettings.gainA);
    assign termB = gainScale(gainScale(SUM_W'(rawB), apparentGainSettings.gainB),
                             activePowerGainSettings.gainB);
    assign termC = gainScale(gainScale(SUM_W'(rawC), apparentGainSettings.gainC),
                             activePowerGainSettings.gainC);

    // Per-term enables
    assign totalPower = (termEnable[0] ? termA : '0)
                      + (termEnable[1] ? termB : '0)
                      + (termEnable[2] ? termC : '0);

    // Accumulation interval
    always_ff @(posedge clock) begin
        if (rst) begin
            periodCnt_q <= ACC_CNT_RST;
        end else if (periodCnt_q == ACC_CNT_LAST) begin
            periodCnt_q <= ACC_CNT_RST;
        end else begin
            periodCnt_q <= periodCnt_q + 4'h1;
        end
    end
    assign accTick = (periodCnt_q == ACC_CNT_LAST);

    // Main accumulator; wraps freely in two's complement
    always_ff @(posedge clock) begin
        if (rst) begin
            accTotal_q <= ACC_RST;
        end else if (accTick) begin
            accTotal_q <= accTotal_q + ACC_W'(totalPower);
        end
    end

    // Clear-on-read accumulator; a sample landing with the read is kept
    always_ff @(posedge clock) begin
        if (rst) begin
            accClear_q <= ACC_RST;
        end else if (clearOnReadStrobe) begin
            accClear_q <= accTick ? ACC_W'(totalPower) : ACC_RST;
        end else if (accTick) begin
            accClear_q <= accClear_q + ACC_W'(totalPower);
        end
    end

    aea_energy_divide totalDivide (
        .clock      (clock),
        .rst        (rst),
        .accValue   (accTotal_q),
        .divSetting (apparentEnergyDivider),
        .energy     (apparentEnergyTotal)
    );

    aea_energy_divide clearDivide (
        .clock      (clock),
        .rst        (rst),
        .accValue   (accClear_q),
        .divSetting (apparentEnergyDivider),
        .energy     (apparentEnergyClearOnRead)
    );

    // Half full: top two bits of the energy become unequal
    always_ff @(posedge clock) begin
        if (rst) begin
            topBitsPrev_q <= 2'h0;
        end else begin
            topBitsPrev_q <= apparentEnergyTotal[ENERGY_W-1 -: 2];
        end
    end
    assign halfEvent = (^apparentEnergyTotal[ENERGY_W-1 -: 2])
                     & ~(^topBitsPrev_q);

    // Sticky flag; a new event wins over the acknowledge
    always_ff @(posedge clock) begin
        if (rst) begin
            halfFullFlag <= 1'b0;
        end else if (halfEvent) begin
            halfFullFlag <= 1'b1;
        end else if (halfFullAck) begin
            halfFullFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~((halfFullFlag | halfEvent) & halfFullEnable);
        end
    end

endmodule // aea_accumulator

// file: dv/aea_accumulator_assertions.sv
// Port-level properties of the apparent energy accumulator.
// Assumes it is bound to aea_accumulator and runs on its one clock.
`timescale 1ns/10ps
module aea_accumulator_checker (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rst,
    // Configuration and strobes
    input wire logic [7:0]            apparentModeRegister,
    input wire logic [7:0]            apparentEnergyDivider,
    input wire aea_pkg::aea_gain_type apparentGainSettings,
    input wire aea_pkg::aea_gain_type activePowerGainSettings,
    input wire logic                  halfFullEnable,
    input wire aea_pkg::aea_rms_type  rmsValues,
    input wire logic                  clearOnReadStrobe,
    input wire logic                  halfFullAck,
    // Results
    input wire logic [23:0]           apparentEnergyTotal,
    input wire logic [23:0]           apparentEnergyClearOnRead,
    input wire logic                  halfFullFlag,
    input wire logic                  irq_n
);
    import aea_pkg::*;
    logic [3:0] tickCnt_q;
    // Mirrors the accumulation interval counter
    always_ff @(posedge clock) begin
        if (rst || tickCnt_q == ACC_CNT_LAST) begin
            tickCnt_q <= ACC_CNT_RST;
        end else begin
            tickCnt_q <= tickCnt_q + 4'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        apparentEnergyTotal == 24'h0 && apparentEnergyClearOnRead == 24'h0 && irq_n)
        else $error("reset left energy or interrupt set");
    irq_follow_a: assert property (
        irq_n == !($past(halfFullEnable)
                   && (halfFullFlag || $past(halfFullFlag && halfFullAck))))
        else $error("interrupt line does not follow flag and enable");
    flag_sticky_a: assert property (halfFullFlag && !halfFullAck |=> halfFullFlag)
        else $error("half-full flag dropped without ack");
    flag_cause_a: assert property ($rose(halfFullFlag) |->
        $past(apparentEnergyTotal[23] != apparentEnergyTotal[22]))
        else $error("half-full flag set below half scale");
    energy_tick_a: assert property ($changed(apparentEnergyTotal) |->
        tickCnt_q == 4'h1 || $past(apparentEnergyDivider) != $past(apparentEnergyDivider, 2))
        else $error("energy moved off the accumulation tick");
    energy_rise_a: assert property (tickCnt_q == 4'h1 &&
        $past(apparentEnergyDivider) == $past(apparentEnergyDivider, 2) |->
        $signed(apparentEnergyTotal) >= $signed($past(apparentEnergyTotal))
        || $past(apparentEnergyTotal[23:22]) == 2'b01)
        else $error("energy fell under positive power");
    clear_read_a: assert property (clearOnReadStrobe && tickCnt_q != ACC_CNT_LAST |-> ##2
        apparentEnergyClearOnRead == 24'h0)
        else $error("read did not clear the copy");
    copy_below_a: assert property (!apparentEnergyTotal[23] |->
        apparentEnergyClearOnRead <= apparentEnergyTotal)
        else $error("clear-on-read copy above total");
endmodule // aea_accumulator_checker

bind aea_accumulator aea_accumulator_checker u_chk (.clock, .rst, .apparentModeRegister,
    .apparentEnergyDivider, .apparentGainSettings, .activePowerGainSettings, .halfFullEnable,
    .rmsValues, .clearOnReadStrobe, .halfFullAck, .apparentEnergyTotal,
    .apparentEnergyClearOnRead, .halfFullFlag, .irq_n);

// file: dv/aea_accumulator_test.sv
// Self-checking random bench for the apparent energy accumulator.
// Assumes aea_pkg, the design and its checker are compiled first.
`timescale 1ns/10ps
`define CHK(got, e, name) begin cmpCount++; if ((got) !== (e)) begin badCount++; \
    $display("CHECK FAILED %s expected %h seen %h", name, e, got); end end
module aea_accumulator_test;
    import aea_pkg::*;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   modeReg = 8'h00;
    logic [7:0]   divReg = 8'h00;
    aea_gain_type active_power_gain_settings = '0;
    aea_gain_type acGain = '0;
    logic         hfEn = 1'b0;
    aea_rms_type  rms = '0;
    logic         clrStrobe = 1'b0;
    logic         hfAck = 1'b0;
    logic [23:0]  eTot, eClr, expTot, expClr;
    logic         hfFlag, irqN;
    logic [48:0]  refAcc, refClr;
    logic [11:0]  g;
    int           refCnt, badCount = 0, cmpCount = 0, cycles = 0;

    always #25 clock = ~clock;

    aea_accumulator DUT (.clock, .rst, .apparentModeRegister(modeReg),
        .apparentEnergyDivider(divReg), .apparentGainSettings(active_power_gain_settings),
        .activePowerGainSettings(acGain), .halfFullEnable(hfEn), .rmsValues(rms),
        .clearOnReadStrobe(clrStrobe), .halfFullAck(hfAck), .apparentEnergyTotal(eTot),
        .apparentEnergyClearOnRead(eClr), .halfFullFlag(hfFlag), .irq_n(irqN));

    function automatic longint termOf(longint v, longint i, longint g1, longint g2);
        longint t;
        t = (v * i) >>> 24;
        t = t + ((t * g1) >>> 12);
        return t + ((t * g2) >>> 12);
    endfunction

    function automatic longint totalOf();
        longint s, v;
        logic [1:0] m;
        m = modeReg[7:6];
        v = (m == 2'b01) ? (rms.voltA + rms.voltC) >> 1
          : (m == 2'b10) ? rms.voltA : rms.voltB;
        s = 0;
        if (modeReg[0]) s += termOf(rms.voltA, rms.currA, active_power_gain_settings.gainA, acGain.gainA);
        if (modeReg[1]) s += termOf(v, rms.currB, active_power_gain_settings.gainB, acGain.gainB);
        if (modeReg[2]) s += termOf(rms.voltC, rms.currC, active_power_gain_settings.gainC, acGain.gainC);
        return s;
    endfunction

    function automatic logic [23:0] energyOf(logic [48:0] acc, logic [7:0] d);
        logic signed [48:0] q;
        q = $signed(acc) / $signed({41'h0, (d == 8'h00) ? 8'h01 : d});
        return q[48:25];
    endfunction

    // Reference accumulators, ticking every twelve clocks after reset
    always @(posedge clock) begin
        if (rst) begin
            refCnt <= 0;
            refAcc <= '0;
            refClr <= '0;
            expTot <= '0;
            expClr <= '0;
        end else begin
            refCnt <= (refCnt == 11) ? 0 : refCnt + 1;
            if (refCnt == 11) refAcc <= refAcc + 49'(totalOf());
            if (clrStrobe) refClr <= (refCnt == 11) ? 49'(totalOf()) : '0;
            else if (refCnt == 11) refClr <= refClr + 49'(totalOf());
            expTot <= energyOf(refAcc, divReg);
            expClr <= energyOf(refClr, divReg);
        end
    end

    always @(negedge clock) if (!rst) begin
        `CHK(eTot, expTot, "energy total")
        `CHK(eClr, expClr, "clear-on-read energy")
        `CHK({hfFlag, irqN}, 2'b01, "half-full flag and interrupt")
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            tally_and_finish();
        end
    end

    // Every mode and enable pattern first, then random settings with gain corners
    initial begin
        void'($urandom(89776));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 64; k++) begin
            @(posedge clock);
            rst <= (k == 40);
            modeReg <= (k < 32) ? {k[1:0], 3'b000, k[4:2]} : 8'($urandom);
            divReg <= (k % 4 == 0) ? 8'(k % 8 == 0) : 8'($urandom);
            g = (k % 3 == 0) ? 12'h7ff : (k % 3 == 1) ? 12'h800 : 12'($urandom);
            active_power_gain_settings <= {g, 12'($urandom), g};
            acGain <= (k % 2 == 1) ? '0 : {3{12'($urandom)}};
            rms <= (k % 5 == 0) ? '1
                 : 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
            hfEn <= 1'($urandom);
            repeat (40 + $urandom % 60) begin
                @(posedge clock);
                clrStrobe <= (k == 10) || ($urandom % 40 == 0);
                hfAck <= ($urandom % 16 == 0);
            end
        end
        tally_and_finish();
    end
endmodule // aea_accumulator_test
